// >>> verilog/trigger_timestamp_counter.sv
// trigger timestamp counter with split reference counting
`timescale 1ns/1ps
// What this block does
// - standard mode clears only on reset commands
// - start-clear mode clears at every card start
// - in standard mode only, wait-edge reset clears, waits edge with timeout
// - internal scheme counts full width on sampling clock
// - rising reference edges advance upper, lower samples
// - falling reference edges advance upper, lower samples
// - capture aux inputs into upper 64 stamp bits
// - no feature means trigger stamps only
// - first A sample stamp in dual time-base
// - report and store trigger source encoding
// - resets act only when clock and setup live
// - plain reset command clears counters
// - reference edge clears lower, increments upper
// - zero timeout disables wait timeout
module trigger_timestamp_counter
   import stamp_pkg::*;
#(
   parameter int timeout_cycles_per_ms = cycles_per_ms
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cmd_write,
   input wire logic [31:0] cmd_data,
   input wire logic [15:0] timeout_ms,
   input wire logic clock_gen_active,
   input wire logic setup_in_hw,
   input wire logic card_start,
   input wire logic trigger,
   input wire logic first_a_sample,
   input wire logic dual_time_base,
   input wire logic [src_width-1:0] trigger_source,
   input wire logic [aux_width-1:0] aux_inputs,
   input wire logic ref_edge_pin,
   output logic [31:0] stamp_command_word,
   output logic [31:0] avail_modes,
   output logic [stamp_width-1:0] stamp_value,
   output logic [aux_width-1:0] stamp_upper,
   output logic stamp_valid,
   output logic wait_busy,
   output logic wait_timeout_flag
);
   // ****************************************
   // reference pin synchroniser
   // ****************************************
   logic [2:0] ref_sync;
   logic ref_level;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         ref_sync <= 3'h0;
      else
         ref_sync <= {ref_sync[1:0], ref_edge_pin};
   end
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         ref_level <= 1'b0;
      else if (ref_sync[1] == ref_sync[2])
         ref_level <= ref_sync[2];
   end
   logic ref_rise;
   logic ref_fall;
   assign ref_rise = (ref_sync[1] == ref_sync[2]) && ref_sync[2] && !ref_level;
   assign ref_fall = (ref_sync[1] == ref_sync[2]) && !ref_sync[2] && ref_level;

   // ****************************************
   // command word
   // ****************************************
   logic [31:0] cmd_mode;
   logic [31:0] cmd_bits;
   logic hw_ready;
   logic do_clear;
   logic do_wait_clear;
   assign cmd_bits = cmd_data & ~(clear_counters_cmd | clear_wait_ref_edge_cmd);
   assign hw_ready = clock_gen_active && setup_in_hw;
   assign do_clear = cmd_write && (cmd_data & clear_counters_cmd) != 32'h0 && hw_ready;
   assign do_wait_clear = cmd_write && (cmd_data & clear_wait_ref_edge_cmd) != 32'h0
      && hw_ready && (cmd_mode & mode_field_mask) == explicit_reset_mode;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         cmd_mode <= cmd_reset_value;
      else if (cmd_write && cmd_bits != 32'h0)
         cmd_mode <= cmd_bits;
   end
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stamp_command_word <= cmd_reset_value;
         avail_modes <= 32'h0;
      end
      else
      begin
         stamp_command_word <= cmd_mode;
         avail_modes <= available_modes_bitmap;
      end
   end

   // ****************************************
   // reference edge wait with timeout
   // ****************************************
   wait_state_t wait_state;
   logic [31:0] wait_cnt;
   logic [15:0] ms_left;
   logic wait_edge;
   logic split_rise;
   logic split_fall;
   assign split_rise = (cmd_mode & count_field_mask) == split_count_rising_ref;
   assign split_fall = (cmd_mode & count_field_mask) == split_count_falling_ref;
   assign wait_edge = (split_fall ? ref_fall : ref_rise);
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_state <= st_idle;
         wait_cnt <= 32'h0;
         ms_left <= timeout_reset_value;
      end
      else
      begin
         case (wait_state)
            st_idle:
            begin
               if (do_wait_clear)
               begin
                  wait_state <= st_wait_edge;
                  wait_cnt <= 32'h0;
                  ms_left <= timeout_ms;
               end
            end
            st_wait_edge:
            begin
               if (wait_edge)
                  wait_state <= st_idle;
               else if (ms_left != 16'h0)
               begin
                  if (wait_cnt == 32'(timeout_cycles_per_ms - 1))
                  begin
                     wait_cnt <= 32'h0;
                     if (ms_left == 16'h1)
                        wait_state <= st_timed_out;
                     ms_left <= ms_left - 16'h1;
                  end
                  else
                     wait_cnt <= wait_cnt + 32'h1;
               end
            end
            st_timed_out:
            begin
               if (do_wait_clear)
               begin
                  wait_state <= st_wait_edge;
                  wait_cnt <= 32'h0;
                  ms_left <= timeout_ms;
               end
               else if (do_clear)
                  wait_state <= st_idle;
            end
            default:
               wait_state <= st_idle;
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_busy <= 1'b0;
         wait_timeout_flag <= 1'b0;
      end
      else
      begin
         wait_busy <= (wait_state == st_wait_edge);
         wait_timeout_flag <= (wait_state == st_timed_out);
      end
   end

   // ****************************************
   // counters
   // ****************************************
   logic [stamp_width-1:0] count;
   logic split_mode;
   logic counter_edge;
   logic hold_clear;
   assign split_mode = split_rise || split_fall;
   assign counter_edge = (split_rise && ref_rise) || (split_fall && ref_fall);
   assign hold_clear = (wait_state != st_idle);
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         count <= '0;
      else if (do_clear || do_wait_clear || hold_clear)
         count <= '0;
      else if ((cmd_mode & mode_field_mask) == start_clear_mode && card_start)
         count <= '0;
      else if (split_mode && counter_edge)
      begin
         count[stamp_width-1 -: upper_width] <= count[stamp_width-1 -: upper_width]
            + 32'h1;
         count[stamp_width-upper_width-1:0] <= '0;
      end
      else if (split_mode)
         count[stamp_width-upper_width-1:0] <= count[stamp_width-upper_width-1:0] + 32'h1;
      else
         count <= count + 64'h1;
   end

   // ****************************************
   // stamp latch
   // ****************************************
   logic stamp_event;
   logic aux_en;
   logic src_en;
   assign aux_en = (cmd_mode & aux_input_capture_en) != 32'h0;
   assign src_en = (cmd_mode & trigger_source_encode) != 32'h0;
   assign stamp_event = trigger || ((cmd_mode & first_a_area_stamp) != no_extra_stamps
      && dual_time_base && first_a_sample);
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stamp_value <= '0;
         stamp_upper <= '0;
         stamp_valid <= 1'b0;
      end
      else
      begin
         stamp_valid <= stamp_event && cmd_mode != cmd_reset_value;
         if (stamp_event)
         begin
            stamp_value <= count;
            if (aux_en)
               stamp_upper <= aux_inputs;
            else if (src_en && trigger)
               stamp_upper <= {{(aux_width-src_width){1'b0}}, trigger_source};
            else
               stamp_upper <= '0;
         end
      end
   end
endmodule

// >>> verilog/stamp_pkg.sv
// constants for the trigger timestamp counter
package stamp_pkg;
   // command word fields
   localparam logic [31:0] clear_counters_cmd = 32'h0000_0001;
   localparam logic [31:0] explicit_reset_mode = 32'h0000_0002;
   localparam logic [31:0] start_clear_mode = 32'h0000_0004;
   localparam logic [31:0] clear_wait_ref_edge_cmd = 32'h0000_0008;
   localparam logic [31:0] full_width_sample_count = 32'h0000_0100;
   localparam logic [31:0] split_count_rising_ref = 32'h0000_0200;
   localparam logic [31:0] split_count_falling_ref = 32'h0000_0400;
   localparam logic [31:0] aux_input_capture_en = 32'h0000_1000;
   localparam logic [31:0] no_extra_stamps = 32'h0000_0000;
   localparam logic [31:0] first_a_area_stamp = 32'h0001_0000;
   localparam logic [31:0] trigger_source_encode = 32'h0002_0000;
   localparam logic [31:0] mode_field_mask = 32'h0000_0006;
   localparam logic [31:0] count_field_mask = 32'h0000_0700;
   // capability bitmap reported to the host
   localparam logic [31:0] available_modes_bitmap = 32'h0003_1706;
   // timeout unit and clock rate
   localparam int ref_clk_hz = 50_000_000;
   localparam int timeout_unit_ms = 1;
   localparam int cycles_per_ms = ref_clk_hz / 1000 * timeout_unit_ms;
   // reset values, widths and wait states
   localparam logic [31:0] cmd_reset_value = 32'h0000_0000;
   localparam logic [15:0] timeout_reset_value = 16'h0000;
   localparam int stamp_width = 64;
   localparam int aux_width = 64;
   localparam int upper_width = 32;
   localparam int src_width = 8;
   typedef enum logic [1:0]
   {
      st_idle = 2'b00,
      st_wait_edge = 2'b01,
      st_timed_out = 2'b10
   } wait_state_t;
endpackage

// >>> tb/ttc_props.sv
// port checker for the timestamp counter
`timescale 1ns/1ps
module ttc_props
   import stamp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic cmd_write,
   input wire logic [31:0] cmd_data,
   input wire logic [15:0] timeout_ms,
   input wire logic clock_gen_active,
   input wire logic setup_in_hw,
   input wire logic trigger,
   input wire logic first_a_sample,
   input wire logic [aux_width-1:0] aux_inputs,
   input wire logic [31:0] stamp_command_word,
   input wire logic [31:0] avail_modes,
   input wire logic [stamp_width-1:0] stamp_value,
   input wire logic [aux_width-1:0] stamp_upper,
   input wire logic stamp_valid,
   input wire logic wait_busy,
   input wire logic wait_timeout_flag
);
   // ***
   // checks
   // ***
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   a_stamp_on_trig: assert property (trigger && stamp_command_word != 32'h0 |=> stamp_valid)
      else $error("no stamp");
   a_only_events: assert property (stamp_valid |-> $past(trigger) || $past(first_a_sample))
      else $error("extra stamp");
   a_modes_bitmap: assert property ($past(nrst) |-> avail_modes == available_modes_bitmap)
      else $error("bad bitmap");
   a_clear_small: assert property (cmd_write && cmd_data == clear_counters_cmd &&
      clock_gen_active && setup_in_hw && stamp_command_word != 0 ##4 trigger
      |=> stamp_value < 64'h8) else $error("not cleared");
   a_wait_cause: assert property ($rose(wait_busy) |-> $past(cmd_write, 2) &&
      $past(cmd_data[3], 2) && $past(clock_gen_active, 2) && $past(setup_in_hw, 2))
      else $error("bad wait");
   a_wait_bound: assert property ($rose(wait_busy) && timeout_ms == 16'h1
      |-> ##[0:20] (wait_timeout_flag || !wait_busy)) else $error("no expiry");
   a_no_timeout: assert property (timeout_ms == 16'h0 |-> !$rose(wait_timeout_flag))
      else $error("timeout when off");
   a_aux_capture: assert property (trigger && stamp_command_word[12]
      |=> stamp_upper == $past(aux_inputs)) else $error("aux lost");
endmodule

// >>> tb/ref_clock_src.sv
// reference clock source model
`timescale 1ns/1ps
module ref_clock_src (
   input wire logic step,
   output logic pin
);
   // ***
   // one edge per step, still otherwise
   // ***
   initial pin = 1'b0;
   always @(posedge step) pin <= #7 ~pin;
endmodule

// >>> tb/tb_trigger_timestamp_counter.sv
// testbench for the timestamp counter
`timescale 1ns/1ps
module tb_trigger_timestamp_counter;
   import stamp_pkg::*;
   logic ref_clk = 1'b0, nrst = 1'b0, cmd_write = 1'b0, card_start = 1'b0, trigger = 1'b0;
   logic clock_gen_active = 1'b1, setup_in_hw = 1'b1, step = 1'b0, dual_time_base = 1'b0;
   logic first_a_sample = 1'b0;
   logic [31:0] cmd_data = '0;
   logic [15:0] timeout_ms = '0;
   logic [7:0] trigger_source = '0;
   logic [63:0] aux_inputs = '0, a, b, stamp_value, stamp_upper;
   logic ref_edge_pin, stamp_valid, wait_busy, wait_timeout_flag;
   logic [31:0] avail_modes, stamp_command_word;
   int fail_count = 0, comparisons = 0, seed = 83802, i;
   always #10 ref_clk = ~ref_clk;
   trigger_timestamp_counter #(.timeout_cycles_per_ms(10)) u_trigger_timestamp_counter (
      .ref_clk, .nrst, .cmd_write, .cmd_data, .timeout_ms, .clock_gen_active, .setup_in_hw,
      .card_start, .trigger, .first_a_sample, .dual_time_base, .trigger_source,
      .aux_inputs, .ref_edge_pin, .stamp_command_word, .avail_modes, .stamp_value,
      .stamp_upper, .stamp_valid, .wait_busy, .wait_timeout_flag);
   ref_clock_src u_ref_clock_src (.step, .pin(ref_edge_pin));
   // ***
   // tasks
   // ***
   task automatic chk(string n, logic [63:0] s, logic [63:0] e);
      comparisons++;
      if (s !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(logic [31:0] v);
      @(posedge ref_clk);
      cmd_write <= 1'b1;
      cmd_data <= v;
      @(posedge ref_clk);
      cmd_write <= 1'b0;
      cyc(2);
   endtask
   task automatic trig(output logic [63:0] t);
      @(posedge ref_clk);
      trigger <= 1'b1;
      aux_inputs <= {$random(seed), $random(seed)};
      trigger_source <= 8'($random(seed));
      @(posedge ref_clk);
      trigger <= 1'b0;
      #1;
      chk("valid", stamp_valid, 1);
      t = stamp_value;
   endtask
   task automatic test_done;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ***
   // scenarios
   // ***
   initial
   begin
      cyc(8);
      nrst <= 1'b1;
      cyc(2);
      chk("modes", avail_modes, available_modes_bitmap);
      wr(explicit_reset_mode | full_width_sample_count);
      chk("cmd word", stamp_command_word, explicit_reset_mode | full_width_sample_count);
      wr(clear_counters_cmd);
      chk("cmd kept", stamp_command_word, explicit_reset_mode | full_width_sample_count);
      trig(a);
      chk("clear", a < 8, 1);
      for (i = 0; i < 2; i++)
      begin
         wr((i ? start_clear_mode : explicit_reset_mode) | full_width_sample_count);
         trig(a);
         @(posedge ref_clk);
         card_start <= 1'b1;
         @(posedge ref_clk);
         card_start <= 1'b0;
         cyc(3);
         trig(b);
         chk("start", i ? b < 8 : b - a, i ? 1 : 7);
      end
      cyc(30);
      for (i = 0; i < 2; i++)
      begin
         clock_gen_active <= i[0];
         setup_in_hw <= !i[0];
         wr(clear_counters_cmd);
         trig(a);
         chk("refused", a > 30, 1);
      end
      clock_gen_active <= 1'b1;
      setup_in_hw <= 1'b1;
      wr(clear_wait_ref_edge_cmd);
      chk("busy", wait_busy, 0);
      wr(explicit_reset_mode | split_count_rising_ref);
      timeout_ms <= 16'h1;
      wr(clear_wait_ref_edge_cmd);
      for (i = 0; i < 40 && wait_timeout_flag !== 1'b1; i++)
         cyc(1);
      chk("expired", wait_timeout_flag, 1);
      if (wait_timeout_flag !== 1'b1)
         test_done;
      trig(a);
      chk("held", a, 0);
      timeout_ms <= 16'h0;
      wr(clear_wait_ref_edge_cmd);
      cyc(30);
      chk("nowait", {wait_busy, wait_timeout_flag}, 2);
      for (i = 0; i < 5; i++)
      begin
         if (i > 0)
            wr(explicit_reset_mode | (i < 3 ? split_count_rising_ref : split_count_falling_ref));
         trig(a);
         step <= 1'b1;
         cyc(1);
         step <= 1'b0;
         cyc(8);
         trig(b);
         if (i == 0)
            chk("edge", wait_busy, 0);
         else
         begin
            chk("upper", b[63:32] - a[63:32], (i < 3) == ref_edge_pin);
            chk("lower", b[31:0] < 32'h10, (i < 3) == ref_edge_pin);
         end
      end
      wr(explicit_reset_mode | full_width_sample_count | aux_input_capture_en);
      trig(a);
      chk("aux", stamp_upper, aux_inputs);
      wr(explicit_reset_mode | full_width_sample_count | trigger_source_encode);
      trig(a);
      chk("src", stamp_upper, 64'(trigger_source));
      dual_time_base <= 1'b1;
      for (i = 0; i < 2; i++)
      begin
         if (i > 0)
            wr(explicit_reset_mode | full_width_sample_count | first_a_area_stamp);
         @(posedge ref_clk);
         first_a_sample <= 1'b1;
         @(posedge ref_clk);
         first_a_sample <= 1'b0;
         #1;
         chk("first a", stamp_valid, i);
      end
      test_done;
   end
endmodule
bind trigger_timestamp_counter ttc_props u_ttc_props (
   .ref_clk, .nrst, .cmd_write, .cmd_data, .timeout_ms, .clock_gen_active, .setup_in_hw,
   .trigger, .first_a_sample, .aux_inputs, .stamp_command_word, .avail_modes, .stamp_value,
   .stamp_upper, .stamp_valid, .wait_busy, .wait_timeout_flag);
